// file: twm_master.sv
// Two-wire bus master with task triggers, event flags and interrupt, on AHB-Lite.
// Assumes one 125 MHz clock; scl and sda are open-drain pins resolved outside.
`timescale 1ns/10ps
module twm_master
	import twm_pkg::*;
#(
	parameter int QTR_CYC = `TWM_QTR_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Two-wire bus pins
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Interrupt
	output logic irq
);
	`include "twm_params.svh"

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	twm_aphase_t ap_q;
	twm_task_t task_w;
	logic [31:0] hrdata_q;
	logic wr_en;
	logic [6:0] addr_q;
	logic [7:0] tx_data_q;
	logic [7:0] rx_data_q;
	logic [7:0] count_q;
	logic [`TWM_EV_COUNT-1:0] flag_q;
	logic [`TWM_EV_COUNT-1:0] ev_set;
	logic [`TWM_EV_COUNT-1:0] irq_stat_q;
	logic [`TWM_EV_COUNT-1:0] irq_mask_q;
	logic irq_q;

	function automatic logic hit(input twm_aphase_t a, input logic [11:0] ofs);
		hit = a.valid && a.write && (a.addr == ofs);
	endfunction

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			ap_q <= '0;
		end else if (hready) begin
			ap_q.valid <= hsel && htrans[1];
			ap_q.write <= hwrite;
			ap_q.addr <= haddr[11:0];
		end
	end

	assign wr_en = ap_q.valid && ap_q.write;
	assign task_w.start_rx = hit(ap_q, `TWM_OFS_START_RX) && hwdata[0];
	assign task_w.start_tx = hit(ap_q, `TWM_OFS_START_TX) && hwdata[0];
	assign task_w.stop = hit(ap_q, `TWM_OFS_STOP) && hwdata[0];
	assign task_w.suspend = hit(ap_q, `TWM_OFS_SUSPEND) && hwdata[0];
	assign task_w.resume = hit(ap_q, `TWM_OFS_RESUME) && hwdata[0];

	// Read data is fetched in the address phase
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hrdata_q <= 32'h0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[11:0])
				`TWM_OFS_STOPPED: hrdata_q <= {31'h0, flag_q[`TWM_EV_STOPPED]};
				`TWM_OFS_ERROR: hrdata_q <= {31'h0, flag_q[`TWM_EV_ERROR]};
				`TWM_OFS_PAUSED: hrdata_q <= {31'h0, flag_q[`TWM_EV_PAUSED]};
				`TWM_OFS_RX_STARTED: hrdata_q <= {31'h0, flag_q[`TWM_EV_RX_STARTED]};
				`TWM_OFS_TX_STARTED: hrdata_q <= {31'h0, flag_q[`TWM_EV_TX_STARTED]};
				`TWM_OFS_ADDRESS: hrdata_q <= {25'h0, addr_q};
				`TWM_OFS_TX_DATA: hrdata_q <= {24'h0, tx_data_q};
				`TWM_OFS_RX_DATA: hrdata_q <= {24'h0, rx_data_q};
				`TWM_OFS_COUNT: hrdata_q <= {24'h0, count_q};
				`TWM_OFS_IRQ_STAT: hrdata_q <= {27'h0, irq_stat_q};
				`TWM_OFS_IRQ_MASK: hrdata_q <= {27'h0, irq_mask_q};
				default: hrdata_q <= 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			addr_q <= 7'h00;
			tx_data_q <= 8'h00;
			count_q <= `TWM_COUNT_RST;
			irq_mask_q <= '0;
		end else begin
			if (hit(ap_q, `TWM_OFS_ADDRESS))
				addr_q <= hwdata[6:0];
			if (hit(ap_q, `TWM_OFS_TX_DATA))
				tx_data_q <= hwdata[7:0];
			if (hit(ap_q, `TWM_OFS_COUNT))
				count_q <= hwdata[7:0];
			if (hit(ap_q, `TWM_OFS_IRQ_MASK))
				irq_mask_q <= hwdata[`TWM_EV_COUNT-1:0];
		end
	end

	// ****************************************************************
	// Event flags and interrupt
	// ****************************************************************
	localparam logic [11:0] FLAG_OFS [`TWM_EV_COUNT] = '{
		`TWM_OFS_STOPPED, `TWM_OFS_ERROR, `TWM_OFS_PAUSED,
		`TWM_OFS_RX_STARTED, `TWM_OFS_TX_STARTED};

	// Hardware set wins over a software write in the same cycle
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			flag_q <= {`TWM_EV_COUNT{`TWM_FLAG_RST}};
		end else begin
			for (int i = 0; i < `TWM_EV_COUNT; i++) begin
				if (ev_set[i])
					flag_q[i] <= 1'b1;
				else if (hit(ap_q, FLAG_OFS[i]))
					flag_q[i] <= hwdata[0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			irq_stat_q <= '0;
		end else if (hit(ap_q, `TWM_OFS_IRQ_STAT)) begin
			irq_stat_q <= (irq_stat_q & ~hwdata[`TWM_EV_COUNT-1:0]) | ev_set;
		end else begin
			irq_stat_q <= irq_stat_q | ev_set;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	// ****************************************************************
	// Pin synchronisers and quarter-bit tick
	// ****************************************************************
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic [15:0] div_q;
	logic tick_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_i};
			sda_sync_q <= {sda_sync_q[0], sda_i};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			div_q <= 16'h0;
			tick_q <= 1'b0;
		end else if (div_q == 16'(QTR_CYC - 1)) begin
			div_q <= 16'h0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h1;
			tick_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Bus engine
	// ****************************************************************
	twm_state_t state_q;
	logic [1:0] phase_q;
	logic [2:0] bit_q;
	logic [7:0] shift_q;
	logic [7:0] left_q;
	logic rd_q;
	logic addr_byte_q;
	logic nack_q;
	logic suspend_pend_q;
	logic stop_pend_q;
	logic scl_oe_q;
	logic sda_oe_q;
	logic step;
	logic byte_done;
	logic to_stop;

	// Stretching: hold the high phase until the slave lets scl rise
	assign step = tick_q && !(phase_q == 2'd2 && scl_oe_q == 1'b0 && !scl_sync_q[1]);
	assign byte_done = (state_q == TWM_ACK) && step && (phase_q == 2'd3);
	// Byte end leads to stop: refused address or data, stop asked, last byte
	assign to_stop = nack_q || stop_pend_q || left_q == 8'h0 || (!addr_byte_q && left_q == 8'h1);

	always_comb begin
		ev_set = '0;
		ev_set[`TWM_EV_STOPPED] = (state_q == TWM_STOP) && step && (phase_q == 2'd3);
		ev_set[`TWM_EV_ERROR] = byte_done && nack_q;
		ev_set[`TWM_EV_PAUSED] = byte_done && suspend_pend_q && !to_stop;
		ev_set[`TWM_EV_RX_STARTED] = (state_q == TWM_IDLE) && task_w.start_rx;
		ev_set[`TWM_EV_TX_STARTED] = (state_q == TWM_IDLE) && task_w.start_tx
			&& !task_w.start_rx;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			suspend_pend_q <= 1'b0;
			stop_pend_q <= 1'b0;
		end else if (state_q == TWM_IDLE) begin
			suspend_pend_q <= 1'b0;
			stop_pend_q <= 1'b0;
		end else begin
			if (task_w.suspend && state_q != TWM_PAUSE)
				suspend_pend_q <= 1'b1;
			else if (byte_done)
				suspend_pend_q <= 1'b0;
			if (task_w.stop && state_q != TWM_PAUSE)
				stop_pend_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			state_q <= TWM_IDLE;
			phase_q <= 2'd0;
			bit_q <= 3'd7;
			shift_q <= 8'h00;
			left_q <= 8'h00;
			rd_q <= 1'b0;
			addr_byte_q <= 1'b0;
			nack_q <= 1'b0;
			rx_data_q <= 8'h00;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				TWM_IDLE: begin
					scl_oe_q <= 1'b0;
					sda_oe_q <= 1'b0;
					phase_q <= 2'd0;
					if (task_w.start_rx || task_w.start_tx) begin
						rd_q <= task_w.start_rx;
						shift_q <= {addr_q, task_w.start_rx};
						left_q <= count_q;
						addr_byte_q <= 1'b1;
						state_q <= TWM_START;
					end
				end
				TWM_START: if (step) begin
					phase_q <= phase_q + 2'd1;
					if (phase_q == 2'd1)
						sda_oe_q <= 1'b1;
					if (phase_q == 2'd3) begin
						scl_oe_q <= 1'b1;
						bit_q <= 3'd7;
						state_q <= TWM_BIT;
					end
				end
				TWM_BIT: if (step) begin
					phase_q <= phase_q + 2'd1;
					case (phase_q)
						2'd0: sda_oe_q <= !(rd_q && !addr_byte_q) && !shift_q[7];
						2'd1: scl_oe_q <= 1'b0;
						2'd2: shift_q <= {shift_q[6:0], sda_sync_q[1]};
						default: begin
							scl_oe_q <= 1'b1;
							bit_q <= bit_q - 3'd1;
							if (bit_q == 3'd0)
								state_q <= TWM_ACK;
						end
					endcase
				end
				TWM_ACK: if (step) begin
					phase_q <= phase_q + 2'd1;
					case (phase_q)
						2'd0: sda_oe_q <= rd_q && !addr_byte_q && left_q != 8'h1;
						2'd1: scl_oe_q <= 1'b0;
						2'd2: nack_q <= (!rd_q || addr_byte_q) && sda_sync_q[1];
						default: begin
							scl_oe_q <= 1'b1;
							if (rd_q && !addr_byte_q)
								rx_data_q <= shift_q;
							shift_q <= rd_q ? 8'hFF : tx_data_q;
							addr_byte_q <= 1'b0;
							bit_q <= 3'd7;
							if (to_stop) begin
								state_q <= TWM_STOP;
							end else begin
								if (!addr_byte_q)
									left_q <= left_q - 8'h1;
								state_q <= suspend_pend_q ? TWM_PAUSE : TWM_BIT;
							end
						end
					endcase
				end
				TWM_PAUSE: begin
					scl_oe_q <= 1'b1;
					phase_q <= 2'd0;
					if (task_w.resume)
						state_q <= TWM_BIT;
				end
				TWM_STOP: if (step) begin
					phase_q <= phase_q + 2'd1;
					case (phase_q)
						2'd0: sda_oe_q <= 1'b1;
						2'd1: scl_oe_q <= 1'b0;
						2'd2: sda_oe_q <= 1'b0;
						default: begin
							nack_q <= 1'b0;
							state_q <= TWM_IDLE;
						end
					endcase
				end
				default: state_q <= TWM_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	logic hresp_q;
	logic hreadyout_q;

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			hresp_q <= 1'b0;
			hreadyout_q <= 1'b1;
		end else begin
			hresp_q <= 1'b0;
			hreadyout_q <= 1'b1;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign irq = irq_q;
endmodule

// file: twm_params.svh
// Offsets, field positions, reset values and timing counts of the two-wire master.
// Assumes inclusion by twm_pkg and by the top module of the block.
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define TWM_OFS_START_RX 12'h000
`define TWM_OFS_START_TX 12'h008
`define TWM_OFS_STOP 12'h014
`define TWM_OFS_SUSPEND 12'h01C
`define TWM_OFS_RESUME 12'h020
`define TWM_OFS_STOPPED 12'h104
`define TWM_OFS_ERROR 12'h124
`define TWM_OFS_PAUSED 12'h148
`define TWM_OFS_RX_STARTED 12'h14C
`define TWM_OFS_TX_STARTED 12'h150
`define TWM_OFS_ADDRESS 12'h588
`define TWM_OFS_TX_DATA 12'h600
`define TWM_OFS_RX_DATA 12'h604
`define TWM_OFS_COUNT 12'h608
`define TWM_OFS_IRQ_STAT 12'h60C
`define TWM_OFS_IRQ_MASK 12'h610
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define TWM_EV_STOPPED 0
`define TWM_EV_ERROR 1
`define TWM_EV_PAUSED 2
`define TWM_EV_RX_STARTED 3
`define TWM_EV_TX_STARTED 4
`define TWM_EV_COUNT 5
`define TWM_FLAG_RST 1'h0
`define TWM_EVENT_ABSENT_VALUE 1'h0
`define TWM_COUNT_RST 8'h01
// ****************************************************************
// Timing
// ****************************************************************
`define TWM_BUS_KHZ 100
`define TWM_CLK_KHZ 125000
`define TWM_QTR_CYC ((`TWM_CLK_KHZ) / (4 * `TWM_BUS_KHZ))
`endif

// file: twm_pkg.sv
// Types shared by the two-wire master: engine states and carriers.
// Assumes twm_params.svh is on the include path.
package twm_pkg;
	`include "twm_params.svh"

	typedef enum logic [5:0] {
		TWM_IDLE = 6'b000001,
		TWM_START = 6'b000010,
		TWM_BIT = 6'b000100,
		TWM_ACK = 6'b001000,
		TWM_PAUSE = 6'b010000,
		TWM_STOP = 6'b100000
	} twm_state_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
	} twm_aphase_t;

	typedef struct packed {
		logic start_rx;
		logic start_tx;
		logic stop;
		logic suspend;
		logic resume;
	} twm_task_t;
endpackage

// file: twm_master_properties.sv
// Checker for the two-wire master: bus reads, event flags, pause on the pins.
// Assumes it is bound to twm_master and sees only its ports.
`timescale 1ns/10ps
`include "twm_params.svh"
module twm_master_properties
	import twm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Pins and interrupt
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic irq
);
	// ****
	// Helper state
	// ****
	logic rd_q, wr_q, busy_q, pau_q;
	logic [11:0] a_q;
	logic [3:0] n_q;
	logic [4:0] stk_q;
	logic [2:0] ix;
	logic go_rx, go_tx, res;
	always_comb begin
		case (a_q)
			`TWM_OFS_STOPPED: ix = 3'h0;
			`TWM_OFS_ERROR: ix = 3'h1;
			`TWM_OFS_PAUSED: ix = 3'h2;
			`TWM_OFS_RX_STARTED: ix = 3'h3;
			`TWM_OFS_TX_STARTED: ix = 3'h4;
			default: ix = 3'h7;
		endcase
	end
	assign go_rx = wr_q && a_q == `TWM_OFS_START_RX && hwdata[0] && !busy_q;
	assign go_tx = wr_q && a_q == `TWM_OFS_START_TX && hwdata[0] && !busy_q;
	assign res = wr_q && a_q == `TWM_OFS_RESUME && hwdata[0];
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else if (hready) begin
			rd_q <= hsel && htrans[1] && !hwrite;
			wr_q <= hsel && htrans[1] && hwrite;
			a_q <= haddr[11:0];
		end
	end
	// Bus start resets the clock-pulse count within a byte
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			busy_q <= 1'b0;
			n_q <= 4'h0;
		end else if ($rose(sda_oe) && !scl_oe) begin
			busy_q <= 1'b1;
			n_q <= 4'h0;
		end else begin
			if ($fell(sda_oe) && !scl_oe)
				busy_q <= 1'b0;
			if ($rose(scl_oe))
				n_q <= (n_q == 4'h8) ? 4'h0 : n_q + 4'h1;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			stk_q <= 5'h0;
			pau_q <= 1'b0;
		end else begin
			if (rd_q && ix < 3'h5 && hrdata[0])
				stk_q[ix] <= 1'b1;
			if (wr_q && ix < 3'h5 && !hwdata[0])
				stk_q[ix] <= 1'b0;
			if (rd_q && ix == 3'h2 && hrdata[0])
				pau_q <= 1'b1;
			if (res)
				pau_q <= 1'b0;
		end
	end
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_resume_reads_zero: assert property (rd_q && a_q == `TWM_OFS_RESUME |-> hrdata == 32'h0)
		else $error("resume trigger read nonzero");
	a_reset_quiet: assert property ($rose(rst_b) |-> !irq && !scl_oe && !sda_oe)
		else $error("activity right after reset");
	a_flag_one_bit: assert property (rd_q && ix < 3'h5 |-> hrdata[31:1] == 31'h0)
		else $error("event flag has upper bits set");
	a_pause_on_byte: assert property (pau_q |-> n_q == 4'h1)
		else $error("pause not at a byte boundary");
	a_pause_holds: assert property (pau_q && !res |=> scl_oe && $stable(sda_oe))
		else $error("bus moved while paused");
	a_rx_starts_bus: assert property (go_rx |-> ##[1:40] $rose(sda_oe) && !scl_oe)
		else $error("receive did not start");
	a_tx_starts_bus: assert property (go_tx |-> ##[1:40] $rose(sda_oe) && !scl_oe)
		else $error("transmit did not start");
	a_flag_sticky: assert property (rd_q && ix < 3'h5 && stk_q[ix] |-> hrdata[0])
		else $error("event flag dropped without clear");
	cover property (pau_q);
	cover property (go_tx);
	cover property (wr_q && a_q == `TWM_OFS_STOP && hwdata[0] && busy_q);
	cover property (rd_q && a_q == `TWM_OFS_ERROR && hrdata[0]);
endmodule
bind twm_master twm_master_properties twm_master_properties_i (.sys_clk(sys_clk),
	.rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .scl_oe(scl_oe),
	.sda_oe(sda_oe), .irq(irq));

// file: twm_slave_model.sv
// Behavioural two-wire slave: acks address and written bytes, sends all ones.
// Assumes pulled-up lines; nack makes it refuse the address.
`timescale 1ns/10ps
module twm_slave_model (
	// Bus lines
	input wire logic scl,
	input wire logic sda,
	// Control and drive
	input wire logic nack,
	output logic pull,
	output logic [7:0] got
);
	logic [7:0] sh = 8'h0;
	logic first = 1'b0;
	logic rd = 1'b0;
	int n = 0;
	initial pull = 1'b0;
	initial got = 8'h0;
	// Start condition restarts the byte
	always @(negedge sda) if (scl) begin
		n = -1;
		first = 1'b1;
	end
	always @(posedge scl) sh = {sh[6:0], sda};
	always @(negedge scl) begin
		n = n + 1;
		if (n == 8) begin
			got = sh;
			if (first)
				rd = sh[0];
			pull = first ? !nack : !rd;
		end else if (n == 9) begin
			pull = 1'b0;
			n = 0;
			first = 1'b0;
		end
	end
endmodule

// file: twm_tb.sv
// Testbench for the two-wire master: register bus tasks, slave model, queue checks.
// Assumes the link runs at 160 ns per bit with QTR_CYC of 5.
`timescale 1ns/10ps
`include "twm_params.svh"
module tb;
	import twm_pkg::*;
	logic sys_clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, nack = 1'b0, mon = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, scl_oe, sda_oe, irq, pull;
	logic [7:0] dat, got;
	logic [31:0] q[$];
	logic [11:0] offs[7] = '{`TWM_OFS_RESUME, `TWM_OFS_STOPPED, `TWM_OFS_ERROR,
		`TWM_OFS_PAUSED, `TWM_OFS_RX_STARTED, `TWM_OFS_TX_STARTED, 12'h700};
	int mismatches = 0, n_tests = 0;
	wire scl = ~scl_oe;
	wire sda = ~(sda_oe | pull);
	always #4 sys_clk = ~sys_clk;
	twm_master #(.QTR_CYC(5)) twm_master_i (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
		.irq(irq));
	twm_slave_model twm_slave_model_i (.scl(scl), .sda(sda), .nack(nack), .pull(pull),
		.got(got));
	// ****
	// Tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("counts: %0d mismatches, %0d comparisons", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input bit c);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		mon <= c;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rv = hrdata;
		mon <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 1'b0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		xfer(1'b0, a, 32'h0, 1'b1);
	endtask
	task automatic poll(input logic [11:0] a);
		int k;
		k = 0;
		rv = 32'h0;
		while (rv[0] !== 1'b1 && k < 3000) begin
			xfer(1'b0, a, 32'h0, 1'b0);
			k++;
		end
		if (rv[0] !== 1'b1)
			check(rv, 32'h1);
	endtask
	// Compares each read made by rd against the oldest note
	always @(posedge sys_clk) if (mon && hreadyout) check(hrdata, q.pop_front());
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
	// ****
	// Tests
	// ****
	initial begin
		rv = $urandom(32'h43ada6c5);
		dat = 8'($urandom) | 8'h01;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		foreach (offs[i]) rd(offs[i], 32'h0);
		$display("test reset done");
		wr(`TWM_OFS_IRQ_MASK, 32'h4);
		wr(`TWM_OFS_ADDRESS, {25'h0, dat[6:0]});
		wr(`TWM_OFS_TX_DATA, {24'h0, dat});
		wr(`TWM_OFS_COUNT, 32'h2);
		wr(`TWM_OFS_START_TX, 32'h1);
		wr(`TWM_OFS_SUSPEND, 32'h1);
		rd(`TWM_OFS_TX_STARTED, 32'h1);
		rd(`TWM_OFS_PAUSED, 32'h0);
		check({31'h0, irq}, 32'h0);
		poll(`TWM_OFS_PAUSED);
		check({31'h0, irq}, 32'h1);
		repeat (100) @(posedge sys_clk);
		rd(`TWM_OFS_STOPPED, 32'h0);
		wr(`TWM_OFS_PAUSED, 32'h0);
		rd(`TWM_OFS_PAUSED, 32'h0);
		wr(`TWM_OFS_RESUME, 32'h1);
		poll(`TWM_OFS_STOPPED);
		rd(`TWM_OFS_ERROR, 32'h0);
		rd(`TWM_OFS_STOPPED, 32'h1);
		check({24'h0, got}, {24'h0, dat});
		wr(`TWM_OFS_IRQ_STAT, 32'h1F);
		rd(`TWM_OFS_IRQ_STAT, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("test transmit done");
		wr(`TWM_OFS_STOPPED, 32'h0);
		rd(`TWM_OFS_STOPPED, 32'h0);
		wr(`TWM_OFS_START_RX, 32'h1);
		rd(`TWM_OFS_RX_STARTED, 32'h1);
		poll(`TWM_OFS_STOPPED);
		rd(`TWM_OFS_RX_DATA, 32'hFF);
		$display("test receive done");
		wr(`TWM_OFS_STOPPED, 32'h0);
		wr(`TWM_OFS_START_TX, 32'h1);
		wr(`TWM_OFS_STOP, 32'h1);
		poll(`TWM_OFS_STOPPED);
		check({24'h0, got}, {24'h0, dat[6:0], 1'b0});
		$display("test stop done");
		wr(`TWM_OFS_STOPPED, 32'h0);
		wr(`TWM_OFS_IRQ_STAT, 32'h1F);
		wr(`TWM_OFS_IRQ_MASK, 32'h0);
		nack <= 1'b1;
		wr(`TWM_OFS_START_TX, 32'h1);
		poll(`TWM_OFS_STOPPED);
		rd(`TWM_OFS_ERROR, 32'h1);
		check({31'h0, irq}, 32'h0);
		wr(`TWM_OFS_IRQ_MASK, 32'h2);
		rd(`TWM_OFS_IRQ_STAT, 32'h13);
		check({31'h0, irq}, 32'h1);
		wr(`TWM_OFS_IRQ_STAT, 32'h2);
		rd(`TWM_OFS_IRQ_STAT, 32'h11);
		check({31'h0, irq}, 32'h0);
		nack <= 1'b0;
		$display("test error done");
		wrap_up();
	end
endmodule
